/* core/stm_pkg.sv */
// constants and types of the supply threshold monitor control block
// assumes one 250 MHz clock and an AXI4-Lite master with 32-bit data
//
// How it works
// - settle interval is a fixed time converted to clock cycles
// - a crossing cannot set the event flag until the settle interval has elapsed
// - monitoring runs from the free clock, not the gated core clock
// - a selected crossing sets the event flag; a wake request rises only while the event enable is also set
// - wake vectors to handler only when global interrupt enable is set
// - every reset returns all registers to reset values, detector off
// - unimplemented bits read as zero and ignore writes
// - enable bit 4 starts settling; read-only bit 5 rises when stable
// - direction bit 7 clear detects falls, set detects rises
// - four-bit trip level picks one of 16; 1111 selects external input
package stm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] STM_OFS_CONTROL  = 4'h0;
  localparam logic [3:0] STM_OFS_FLAGS    = 4'h4;
  localparam logic [3:0] STM_OFS_ENABLES  = 4'h8;
  localparam logic [3:0] STM_OFS_PRIORITY = 4'hC;
  localparam logic [3:0] STM_OFS_CORE     = 4'h0; // spare alias unused

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STM_BIT_DIR       = 7;
  localparam int STM_BIT_BG_STABLE = 6;
  localparam int STM_BIT_STABLE    = 5;
  localparam int STM_BIT_ENABLE    = 4;
  localparam int STM_LEVEL_MSB     = 3;
  localparam int STM_BIT_EVENT     = 2;
  localparam int STM_BIT_GIE       = 0;

  localparam logic [3:0] STM_LEVEL_EXT = 4'hF;
  localparam logic [7:0] STM_CTRL_RST  = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int STM_CLK_MHZ       = 250;
  localparam int STM_SETTLE_US     = 25;
  localparam int STM_SETTLE_CYCLES = STM_SETTLE_US * STM_CLK_MHZ;

  localparam logic [1:0] STM_RESP_OKAY   = 2'b00;
  localparam logic [1:0] STM_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       direction_select;
    logic       detector_enable;
    logic [3:0] trip_level;
  } stm_ctrl_type;

  typedef enum logic [2:0] {
    STM_OFF    = 3'b001,
    STM_SETTLE = 3'b010,
    STM_ARMED  = 3'b100
  } stm_state_type;

endpackage : stm_pkg

/* core/stm_sync.sv */
// two-stage synchronizer for one asynchronous level
// assumes the input is unrelated to aclk
module stm_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : stm_sync

/* core/stm_top.sv */
// supply threshold monitor: registers, settle timer, event flag, wake
// assumes an AXI4-Lite master on aclk and an analog front end that
// reports comparator state as an asynchronous level
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
module stm_top
  import stm_pkg::*;
#(
  parameter int SETTLE_CYCLES = STM_SETTLE_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        comp_above,
  input  wire logic        bandgap_stable,
  output stm_ctrl_type     analog_ctrl,
  output logic             wake_request,
  output logic             irq_vector_request
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  stm_ctrl_type  ctrl_reg, ctrl_next;
  stm_state_type state_reg, state_next;
  logic [31:0]   cnt_reg, cnt_next;
  logic          flag_reg, flag_next;
  logic          ien_reg, ien_next;
  logic          ipr_reg, ipr_next;
  logic          gie_reg, gie_next;
  logic          prev_reg, prev_next;
  logic          aw_reg, aw_next;
  logic          w_reg, w_next;
  logic [3:0]    awa_reg, awa_next;
  logic [31:0]   wd_reg, wd_next;
  logic          wb_reg, wb_next;
  logic          bv_reg, bv_next;
  logic [1:0]    br_reg, br_next;
  logic          rv_reg, rv_next;
  logic [31:0]   rd_reg, rd_next;
  logic [1:0]    rr_reg, rr_next;
  logic          cmp_sync;
  logic          crossing;
  logic          do_write;
  logic          bg_s;

  stm_sync u_cmp (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (comp_above),
    .sync_out (cmp_sync)
  );

  stm_sync u_bg (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (bandgap_stable),
    .sync_out (bg_s)
  );

  // ------------------------------------------------------------------
  // detector
  // ------------------------------------------------------------------
  // direction picks edge
  assign crossing = ctrl_reg.direction_select ? (cmp_sync && !prev_reg)
                                              : (!cmp_sync && prev_reg);
  assign do_write = aw_reg && w_reg && !bv_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    prev_next  = cmp_sync;
    unique case (state_reg)
      STM_OFF: begin
        cnt_next = '0;
        if (ctrl_reg.detector_enable) begin
          state_next = STM_SETTLE;
        end
      end
      STM_SETTLE: begin
        if (!ctrl_reg.detector_enable) begin
          state_next = STM_OFF;
        end else if (cnt_reg >= 32'(SETTLE_CYCLES - 1)) begin
          state_next = STM_ARMED;
        end else begin
          cnt_next = cnt_reg + 32'h0000_0001;
        end
      end
      STM_ARMED: begin
        if (!ctrl_reg.detector_enable) begin
          state_next = STM_OFF;
        end
      end
      default: state_next = STM_OFF;
    endcase
  end

  // ------------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ------------------------------------------------------------------
  always_comb begin
    aw_next   = aw_reg;
    w_next    = w_reg;
    awa_next  = awa_reg;
    wd_next   = wd_reg;
    wb_next   = wb_reg;
    bv_next   = bv_reg;
    br_next   = br_reg;
    rv_next   = rv_reg;
    rd_next   = rd_reg;
    rr_next   = rr_reg;
    ctrl_next = ctrl_reg;
    flag_next = flag_reg;
    ien_next  = ien_reg;
    ipr_next  = ipr_reg;
    gie_next  = gie_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next  = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next  = 1'b1;
      wd_next = s_axi_wdata;
      wb_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      bv_next = 1'b1;
      br_next = STM_RESP_OKAY;
      if (wb_reg) begin
        unique case (awa_reg)
          STM_OFS_CONTROL: begin
            ctrl_next.direction_select = wd_reg[STM_BIT_DIR];
            ctrl_next.detector_enable  = wd_reg[STM_BIT_ENABLE];
            ctrl_next.trip_level       = wd_reg[STM_LEVEL_MSB:0];
          end
          STM_OFS_FLAGS: begin
            flag_next = wd_reg[STM_BIT_EVENT];
            gie_next  = wd_reg[STM_BIT_GIE];
          end
          STM_OFS_ENABLES:  ien_next = wd_reg[STM_BIT_EVENT];
          STM_OFS_PRIORITY: ipr_next = wd_reg[STM_BIT_EVENT];
          default:          br_next  = STM_RESP_SLVERR;
        endcase
      end
    end
    if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    // flag only when armed; set beats clear
    if (state_reg == STM_ARMED && crossing) begin
      flag_next = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rr_next = STM_RESP_OKAY;
      rd_next = '0;
      unique case (s_axi_araddr)
        STM_OFS_CONTROL: begin
          rd_next[STM_BIT_DIR]       = ctrl_reg.direction_select;
          rd_next[STM_BIT_BG_STABLE] = bg_s;
          rd_next[STM_BIT_STABLE]    = (state_reg == STM_ARMED);
          rd_next[STM_BIT_ENABLE]    = ctrl_reg.detector_enable;
          rd_next[STM_LEVEL_MSB:0]   = ctrl_reg.trip_level;
        end
        STM_OFS_FLAGS: begin
          rd_next[STM_BIT_EVENT] = flag_reg;
          rd_next[STM_BIT_GIE]   = gie_reg;
        end
        STM_OFS_ENABLES:  rd_next[STM_BIT_EVENT] = ien_reg;
        STM_OFS_PRIORITY: rd_next[STM_BIT_EVENT] = ipr_reg;
        default:          rr_next = STM_RESP_SLVERR;
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= STM_OFF;
      cnt_reg   <= '0;
      prev_reg  <= 1'b0;
      ctrl_reg  <= stm_ctrl_type'(STM_CTRL_RST[5:0]);
      flag_reg  <= 1'b0;
      ien_reg   <= 1'b0;
      ipr_reg   <= 1'b0;
      gie_reg   <= 1'b0;
      aw_reg    <= 1'b0;
      w_reg     <= 1'b0;
      awa_reg   <= '0;
      wd_reg    <= '0;
      wb_reg    <= 1'b0;
      bv_reg    <= 1'b0;
      br_reg    <= STM_RESP_OKAY;
      rv_reg    <= 1'b0;
      rd_reg    <= '0;
      rr_reg    <= STM_RESP_OKAY;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      prev_reg  <= prev_next;
      ctrl_reg  <= ctrl_next;
      flag_reg  <= flag_next;
      ien_reg   <= ien_next;
      ipr_reg   <= ipr_next;
      gie_reg   <= gie_next;
      aw_reg    <= aw_next;
      w_reg     <= w_next;
      awa_reg   <= awa_next;
      wd_reg    <= wd_next;
      wb_reg    <= wb_next;
      bv_reg    <= bv_next;
      br_reg    <= br_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
      rr_reg    <= rr_next;
    end
  end

  assign s_axi_awready = !aw_reg && !bv_reg;
  assign s_axi_wready  = !w_reg && !bv_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;

  // level 1111 selects external input in the analog mux
  assign analog_ctrl = ctrl_reg;
  assign wake_request = flag_reg && ien_reg;
  assign irq_vector_request = flag_reg && ien_reg && gie_reg;

endmodule : stm_top

/* dv/stm_chk.sv */
// port checker for stm_top
// assumes binding into stm_top with its settle count
module stm_chk
  import stm_pkg::*;
#(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic [3:0]   s_axi_awaddr,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic [31:0]  s_axi_wdata,
  input wire logic [3:0]   s_axi_wstrb,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic         s_axi_rvalid,
  input wire stm_ctrl_type analog_ctrl,
  input wire logic         wake_request,
  input wire logic         irq_vector_request
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------
  // enabled cycle count
  // ------
  logic [15:0] en_cnt_reg;
  logic [15:0] en_cnt_next;
  logic        wr_go;

  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                 && s_axi_wready;

  always_comb begin
    en_cnt_next = en_cnt_reg;
    if (!analog_ctrl.detector_enable) en_cnt_next = 16'h0000;
    else if (en_cnt_reg != 16'hFFFF) en_cnt_next = en_cnt_reg + 16'h0001;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) en_cnt_reg <= 16'h0000;
    else en_cnt_reg <= en_cnt_next;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_clears: assert property (
    $rose(aresetn) |-> analog_ctrl == '0 && !wake_request
      && !s_axi_bvalid && !s_axi_rvalid) else $error("reset left state");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == '0) else $error("upper bits");
  a_stable_time: assert property (
    s_axi_rvalid && s_axi_rdata[STM_BIT_STABLE]
    |-> en_cnt_reg >= SETTLE_CYCLES)
    else $error("stable too early");
  a_vector_wake: assert property (
    irq_vector_request |-> wake_request) else $error("vector no wake");
  a_ctrl_write: assert property (
    wr_go && s_axi_awaddr == STM_OFS_CONTROL && s_axi_wstrb[0] |-> ##3
    analog_ctrl == {$past(s_axi_wdata[7], 3), $past(s_axi_wdata[4], 3),
    $past(s_axi_wdata[3:0], 3)}) else $error("control not applied");
  a_write_answer: assert property (
    wr_go |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("rd late");
  a_busy_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("busy");

  c_wake: cover property ($rose(wake_request));
  c_vector: cover property (irq_vector_request);
  c_stable: cover property (s_axi_rvalid && s_axi_rdata[5]);
endmodule : stm_chk

bind stm_top stm_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) stm_chk_i (.*);

/* dv/tb.sv */
// self-checking bench for stm_top over its register bus
// assumes a short settle count and comparator driven here
module tb
  import stm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ST = 20;

  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic [3:0]   s_axi_awaddr = 4'h0;
  logic [3:0]   s_axi_araddr = 4'h0;
  logic [3:0]   s_axi_wstrb = 4'h1;
  logic [31:0]  s_axi_wdata = 32'h0000_0000;
  logic         s_axi_awvalid = 1'b0;
  logic         s_axi_wvalid = 1'b0;
  logic         s_axi_arvalid = 1'b0;
  logic         s_axi_bready = 1'b1;
  logic         s_axi_rready = 1'b1;
  logic         comp_above = 1'b1;
  logic         bandgap_stable = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_arready;
  logic         s_axi_bvalid, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp, rr;
  logic [31:0]  s_axi_rdata, rd;
  stm_ctrl_type analog_ctrl;
  logic         wake_request, irq_vector_request;
  logic [3:0]   lv;
  int           err_total = 0;
  int           check_count = 0;
  int           cyc = 0;

  stm_top #(.SETTLE_CYCLES(ST)) stm_top_i (.*);

  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  // each channel is sampled at the rising edge that moves it
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic da;
    logic dw;
    da = 1'b0;
    dw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        da = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rr = s_axi_bresp;
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    chk(rd, e);
  endtask : rc

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) rc(4'(i * 4), 32'h0000_0000);
    rc(4'h2, 32'h0000_0000);
    chk(rr, STM_RESP_SLVERR);
    wr(4'h6, 32'hFFFF_FFFF);
    chk(rr, STM_RESP_SLVERR);
    wr(4'h4, 32'hFFFF_FFFF);
    chk(rr, STM_RESP_OKAY);
    rc(4'h4, 32'h0000_0005);
    wr(4'h8, 32'hFFFF_FFFF);
    rc(4'h8, 32'h0000_0004);
    chk(wake_request, 1'b1);
    chk(irq_vector_request, 1'b1);
    wr(4'h4, 32'h0000_0004);
    chk(irq_vector_request, 1'b0);
    wr(4'h4, 32'h0000_0000);
    chk(wake_request, 1'b0);
    wr(4'hC, 32'hFFFF_FFFF);
    rc(4'hC, 32'h0000_0004);
    // a write without its low byte strobe must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(4'h8, 32'h0000_0000);
    s_axi_wstrb <= 4'h1;
    rc(4'h8, 32'h0000_0004);
    for (int i = 0; i < 16; i++) begin
      lv = 4'(i);
      wr(4'h0, {24'h00_0000, lv[0], 3'b000, lv});
      rc(4'h0, {24'h00_0000, lv[0], 3'b000, lv});
      chk(analog_ctrl.trip_level, lv);
      chk(analog_ctrl.direction_select, lv[0]);
    end
    wr(4'h0, 32'h0000_0015);
    rc(4'h0, 32'h0000_0015);
    // falling crossing while the reference settles
    comp_above <= 1'b0;
    repeat (8) @(posedge aclk);
    comp_above <= 1'b1;
    repeat (ST) @(posedge aclk);
    rc(4'h4, 32'h0000_0000);
    rc(4'h0, 32'h0000_0035);
    comp_above <= 1'b0;
    repeat (8) @(posedge aclk);
    rc(4'h4, 32'h0000_0004);
    chk(wake_request, 1'b1);
    wr(4'h4, 32'h0000_0000);
    comp_above <= 1'b1;
    repeat (8) @(posedge aclk);
    rc(4'h4, 32'h0000_0000);
    wr(4'h0, 32'h0000_0000);
    bandgap_stable <= 1'b1;
    wr(4'h0, 32'h0000_009F);
    repeat (ST + 4) @(posedge aclk);
    comp_above <= 1'b0;
    repeat (8) @(posedge aclk);
    rc(4'h4, 32'h0000_0000);
    rc(4'h0, 32'h0000_00FF);
    chk(analog_ctrl.trip_level, STM_LEVEL_EXT);
    comp_above <= 1'b1;
    repeat (8) @(posedge aclk);
    rc(4'h4, 32'h0000_0004);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(4'h4, 32'h0000_0000);
    rc(4'h8, 32'h0000_0000);
    rc(4'hC, 32'h0000_0000);
    // band gap status needs its synchronizer refilled after reset
    rc(4'h0, 32'h0000_0040);
    chk(analog_ctrl, 32'h0000_0000);
    end_sim();
  end
endmodule : tb
